// File: hdl/drive_status_and_speed_scaling.v
`include "drive_status_regs.vh"
module drive_status_and_speed_scaling (
  // Clock, reset and enable
  input  wire        mclk,
  input  wire        resetn,
  input  wire        ce,
  // Wishbone slave
  input  wire        wb_cyc_i,
  input  wire        wb_stb_i,
  input  wire        wb_we_i,
  input  wire [3:0]  wb_adr_i,
  input  wire [3:0]  wb_sel_i,
  input  wire [31:0] wb_dat_i,
  output reg  [31:0] wb_dat_o,
  output reg         wb_ack_o,
  // Drive conditions
  input  wire        control_ready,
  input  wire        coast_active,
  input  wire        start_enabled,
  input  wire        trip,
  input  wire        trip_reset,
  input  wire        error_no_trip,
  input  wire        triplock,
  input  wire        warning,
  input  wire        speed_match,
  input  wire        bus_control_ok,
  input  wire        freq_in_limits,
  input  wire        start_signal,
  input  wire        overtemp_stop,
  input  wire        dc_voltage_bad,
  input  wire        current_over_limit,
  input  wire        motor_timer_over,
  input  wire        drive_timer_over,
  input  wire        link_fault,
  // Actual output, signed, 16384 is 100 percent
  input  wire [15:0] actual_output,
  // Speed reference to motor control
  output reg  [15:0] speed_reference,
  output reg         reference_reverse,
  output reg  [14:0] reference_magnitude
);
  wire [15:0] status_word;
  reg  [15:0] actual_output_value;
  reg  [15:0] control;
  reg  [15:0] next_speed_reference;
  wire        wb_req;

  // The positive ceiling is held wide so the magnitude takes its low 15 bits on purpose.
  localparam [15:0] max_pos = `SCALE_MAX_POS;

  status_capture u_status_capture (
    .mclk               (mclk),
    .resetn             (resetn),
    .ce                 (ce),
    .control_ready      (control_ready),
    .coast_active       (coast_active),
    .start_enabled      (start_enabled),
    .trip               (trip),
    .trip_reset         (trip_reset),
    .error_no_trip      (error_no_trip),
    .triplock           (triplock),
    .warning            (warning),
    .speed_match        (speed_match),
    .bus_control_ok     (bus_control_ok),
    .freq_in_limits     (freq_in_limits),
    .start_signal       (start_signal),
    .output_freq        (actual_output),
    .overtemp_stop      (overtemp_stop),
    .dc_voltage_bad     (dc_voltage_bad),
    .current_over_limit (current_over_limit),
    .motor_timer_over   (motor_timer_over),
    .drive_timer_over   (drive_timer_over),
    .link_fault         (link_fault),
    .status_word        (status_word)
  );

  // Two's complement magnitude; the most negative value saturates.
  function [14:0] magnitude;
    input [15:0] v;
    reg   [15:0] n;
    begin
      n = (~v) + 16'h0001;
      if (!v[15]) begin
        magnitude = v[14:0];
      end else if (n[15]) begin
        magnitude = max_pos[14:0];
      end else begin
        magnitude = n[14:0];
      end
    end
  endfunction

  assign wb_req = wb_cyc_i & wb_stb_i & ~wb_ack_o;

  // Control bit 0 selects whether a write clamps the reference to +-100 percent.
  always @* begin
    next_speed_reference = speed_reference;
    if (wb_sel_i[0]) begin
      next_speed_reference[7:0] = wb_dat_i[7:0];
    end
    if (wb_sel_i[1]) begin
      next_speed_reference[15:8] = wb_dat_i[15:8];
    end
    if (control[0]) begin
      if (!next_speed_reference[15] && next_speed_reference > `SCALE_FULL) begin
        next_speed_reference = `SCALE_FULL;
      end else if (next_speed_reference[15] && next_speed_reference < (~`SCALE_FULL + 16'h0001)) begin
        next_speed_reference = ~`SCALE_FULL + 16'h0001;
      end
    end
  end

  always @(posedge mclk or negedge resetn) begin
    if (!resetn) begin
      wb_ack_o            <= 1'b0;
      wb_dat_o            <= 32'h00000000;
      speed_reference     <= `RST_SPEED_REFERENCE;
      reference_reverse   <= 1'b0;
      reference_magnitude <= 15'h0000;
      control             <= `RST_CONTROL;
      actual_output_value <= `RST_ACTUAL_OUTPUT;
    end else if (ce) begin
      actual_output_value <= actual_output;
      reference_reverse   <= speed_reference[15];
      reference_magnitude <= magnitude(speed_reference);
      wb_ack_o            <= wb_req;
      wb_dat_o            <= 32'h00000000;
      if (wb_req) begin
        if (wb_we_i) begin
          if (wb_adr_i == `OFS_SPEED_REFERENCE) begin
            speed_reference <= next_speed_reference;
          end
          if (wb_adr_i == `OFS_CONTROL) begin
            if (wb_sel_i[0]) begin
              control[7:0] <= wb_dat_i[7:0];
            end
            if (wb_sel_i[1]) begin
              control[15:8] <= wb_dat_i[15:8];
            end
          end
        end else begin
          case (wb_adr_i)
            `OFS_STATUS_WORD:     wb_dat_o <= {16'h0000, status_word};
            `OFS_ACTUAL_OUTPUT:   wb_dat_o <= {16'h0000, actual_output_value};
            `OFS_SPEED_REFERENCE: wb_dat_o <= {16'h0000, speed_reference};
            `OFS_CONTROL:         wb_dat_o <= {16'h0000, control};
            default:              wb_dat_o <= 32'h00000000;
          endcase
        end
      end
    end
  end
endmodule // drive_status_and_speed_scaling

// File: hdl/status_capture.v
`include "drive_status_regs.vh"
module status_capture (
  // Clock, reset and enable
  input  wire        mclk,
  input  wire        resetn,
  input  wire        ce,
  // Raw drive conditions
  input  wire        control_ready,
  input  wire        coast_active,
  input  wire        start_enabled,
  input  wire        trip,
  input  wire        trip_reset,
  input  wire        error_no_trip,
  input  wire        triplock,
  input  wire        warning,
  input  wire        speed_match,
  input  wire        bus_control_ok,
  input  wire        freq_in_limits,
  input  wire        start_signal,
  input  wire [15:0] output_freq,
  input  wire        overtemp_stop,
  input  wire        dc_voltage_bad,
  input  wire        current_over_limit,
  input  wire        motor_timer_over,
  input  wire        drive_timer_over,
  input  wire        link_fault,
  // Captured word
  output reg  [15:0] status_word
);
  reg         trip_held;
  reg  [15:0] next_status_word;
  wire        trip_now;

  // Trip latches until reset; a trip in the reset cycle still wins.
  assign trip_now = trip | (trip_held & ~trip_reset);

  always @(posedge mclk or negedge resetn) begin
    if (!resetn) begin
      trip_held <= 1'b0;
    end else if (ce) begin
      trip_held <= trip_now;
    end
  end

  always @* begin
    next_status_word = 16'h0000;
    next_status_word[`BIT_CONTROL_READY] = control_ready & ~trip_now;
    next_status_word[`BIT_DRIVE_READY]   = control_ready & ~trip_now & coast_active;
    next_status_word[`BIT_ENABLE]        = start_enabled & ~coast_active;
    next_status_word[`BIT_TRIP]          = trip_now;
    next_status_word[`BIT_ERROR]         = error_no_trip;
    next_status_word[`BIT_RESERVED]      = 1'b0;
    next_status_word[`BIT_TRIPLOCK]      = triplock;
    next_status_word[`BIT_WARNING]       = warning;
    next_status_word[`BIT_SPEED_MATCH]   = speed_match;
    next_status_word[`BIT_BUS_CONTROL]   = bus_control_ok;
    next_status_word[`BIT_FREQ_LIMIT_OK] = freq_in_limits;
    next_status_word[`BIT_IN_OPERATION]  = start_signal | (output_freq != 16'h0000);
    next_status_word[`BIT_OVERTEMP_STOP] = overtemp_stop;
    next_status_word[`BIT_VOLTAGE_EXC]   = dc_voltage_bad;
    next_status_word[`BIT_TORQUE_EXC]    = current_over_limit;
    next_status_word[`BIT_TIMER_EXC]     = motor_timer_over | drive_timer_over;
    if (link_fault) begin
      next_status_word = 16'h0000;
    end
  end

  // One register for all sixteen bits keeps a read coherent.
  always @(posedge mclk or negedge resetn) begin
    if (!resetn) begin
      status_word <= `RST_STATUS_WORD;
    end else if (ce) begin
      status_word <= next_status_word;
    end
  end
endmodule // status_capture

// File: shared/drive_status_regs.vh
`ifndef DRIVE_STATUS_REGS_VH
`define DRIVE_STATUS_REGS_VH
`define OFS_STATUS_WORD     4'h0
`define OFS_ACTUAL_OUTPUT   4'h4
`define OFS_SPEED_REFERENCE 4'h8
`define OFS_CONTROL         4'hc
`define RST_STATUS_WORD     16'h0000
`define RST_ACTUAL_OUTPUT   16'h0000
`define RST_SPEED_REFERENCE 16'h0000
`define RST_CONTROL         16'h0000
`define SCALE_FULL          16'h4000
`define SCALE_MAX_POS       16'h7fff
`define BIT_CONTROL_READY   0
`define BIT_DRIVE_READY     1
`define BIT_ENABLE          2
`define BIT_TRIP            3
`define BIT_ERROR           4
`define BIT_RESERVED        5
`define BIT_TRIPLOCK        6
`define BIT_WARNING         7
`define BIT_SPEED_MATCH     8
`define BIT_BUS_CONTROL     9
`define BIT_FREQ_LIMIT_OK   10
`define BIT_IN_OPERATION    11
`define BIT_OVERTEMP_STOP   12
`define BIT_VOLTAGE_EXC     13
`define BIT_TORQUE_EXC      14
`define BIT_TIMER_EXC       15
`endif

// File: sim/drive_status_chk.sv
module drive_status_chk (
  // Clock, reset and enable
  input wire        mclk,
  input wire        resetn,
  input wire        ce,
  // Bus
  input wire        wb_cyc_i,
  input wire        wb_stb_i,
  input wire        wb_we_i,
  input wire [3:0]  wb_adr_i,
  input wire [31:0] wb_dat_o,
  input wire        wb_ack_o,
  // Conditions and reference
  input wire        trip,
  input wire        link_fault,
  input wire [15:0] actual_output,
  input wire [15:0] speed_reference,
  input wire        reference_reverse,
  input wire [14:0] reference_magnitude
);
  default clocking @(posedge mclk); endclocking
  default disable iff (!resetn);
  // The request is still held at the edge that samples ack, so no history is needed here.
  wire st_rd = wb_ack_o && !wb_we_i && wb_adr_i == 4'h0;
  link_zero_a: assert property (st_rd && $past(link_fault, 2) |-> wb_dat_o[15:0] == 16'h0000)
    else $error("status not cleared on link fault");
  reserved_bit_a: assert property (st_rd |-> !wb_dat_o[5])
    else $error("reserved status bit set");
  trip_shows_a: assert property (st_rd && $past(trip, 2) && !$past(link_fault, 2) |-> wb_dat_o[3] && !wb_dat_o[0])
    else $error("trip not reported");
  actual_read_a: assert property (wb_ack_o && !wb_we_i && wb_adr_i == 4'h4 |-> wb_dat_o == {16'h0000, $past(actual_output, 2)})
    else $error("actual output read wrong");
  sign_track_a: assert property ($past(ce) |-> reference_reverse == $past(speed_reference[15]))
    else $error("reverse flag wrong");
  magnitude_a: assert property ($past(ce) && !$past(speed_reference[15]) |-> reference_magnitude == $past(speed_reference[14:0]))
    else $error("magnitude wrong");
  ref_hold_a: assert property (!(wb_ack_o && $past(wb_we_i && wb_adr_i == 4'h8)) |-> $stable(speed_reference))
    else $error("reference changed without write");
  ack_timing_a: assert property (wb_cyc_i && wb_stb_i && ce && !wb_ack_o |=> wb_ack_o)
    else $error("ack late");
  ack_pulse_a: assert property (wb_ack_o |=> !wb_ack_o)
    else $error("ack held");
  cover property (st_rd && $past(link_fault, 2));
  cover property (st_rd && $past(trip, 2));
  cover property (wb_ack_o && wb_we_i && wb_adr_i == 4'h8 ##2 reference_reverse);
endmodule // drive_status_chk
bind drive_status_and_speed_scaling drive_status_chk chk (.mclk, .resetn, .ce, .wb_cyc_i, .wb_stb_i, .wb_we_i,
  .wb_adr_i, .wb_dat_o, .wb_ack_o, .trip, .link_fault, .actual_output, .speed_reference, .reference_reverse,
  .reference_magnitude);

// File: sim/fieldbus_master.sv
module fieldbus_master (
  // Clock
  input  wire         mclk,
  // Request
  output logic        cyc,
  output logic        stb,
  output logic        we,
  output logic [3:0]  adr,
  output logic [3:0]  sel,
  output logic [31:0] dat,
  // Answer
  input  wire         ack,
  input  wire  [31:0] q
);
  timeunit 1ns;
  timeprecision 1ps;
  initial {cyc, stb, we, adr, sel, dat} = '0;
  // Called just after an edge; ack is seen with its pre-edge value, so no race.
  task automatic xfer(input logic w, input logic [3:0] a, input logic [31:0] d, output logic [31:0] r);
    cyc <= 1'b1;
    stb <= 1'b1;
    we <= w;
    adr <= a;
    sel <= 4'h3;
    dat <= d;
    @(posedge mclk);
    while (ack !== 1'b1) @(posedge mclk);
    r = q;
    cyc <= 1'b0;
    stb <= 1'b0;
    sel <= 4'h0;
    dat <= ~d;
    @(posedge mclk);
  endtask
endmodule // fieldbus_master

// File: sim/testbench.sv
module testbench;
  timeunit 1ns;
  timeprecision 1ps;
  logic        mclk, resetn, cyc, stb, we, ack, rev;
  logic [3:0]  adr, sel;
  logic [31:0] wd, q, r;
  logic [17:0] c, k;
  logic [15:0] act, sref, v, m16;
  logic [14:0] mag;
  logic [15:0] refs [4] = '{16'h4000, 16'hc000, 16'h7fff, 16'h8000};
  int          failures = 0, cmp_count = 0, ticks = 0;
  fieldbus_master m (.mclk, .cyc, .stb, .we, .adr, .sel, .dat(wd), .ack, .q);
  drive_status_and_speed_scaling dut (
    .mclk, .resetn, .ce(1'b1), .wb_cyc_i(cyc), .wb_stb_i(stb), .wb_we_i(we), .wb_adr_i(adr),
    .wb_sel_i(sel), .wb_dat_i(wd), .wb_dat_o(q), .wb_ack_o(ack),
    .control_ready(c[0]), .coast_active(c[1]), .start_enabled(c[2]), .trip(c[3]), .trip_reset(c[4]),
    .error_no_trip(c[5]), .triplock(c[6]), .warning(c[7]), .speed_match(c[8]), .bus_control_ok(c[9]),
    .freq_in_limits(c[10]), .start_signal(c[11]), .overtemp_stop(c[12]), .dc_voltage_bad(c[13]),
    .current_over_limit(c[14]), .motor_timer_over(c[15]), .drive_timer_over(c[16]), .link_fault(c[17]),
    .actual_output(act), .speed_reference(sref), .reference_reverse(rev), .reference_magnitude(mag));
  initial begin
    mclk = 1'b0;
    forever #2.5 mclk = ~mclk;
  end
  function automatic logic [31:0] exp_sw(input logic [17:0] n, input logic [15:0] a);
    logic [15:0] e;
    e = {n[15] | n[16], n[14:12], n[11] | (a != 16'h0000), n[10:6], 1'b0, n[5], n[3],
         n[2] & ~n[1], n[0] & ~n[3] & n[1], n[0] & ~n[3]};
    return {16'h0000, n[17] ? 16'h0000 : e};
  endfunction
  task automatic check(input logic [31:0] seen, input logic [31:0] expd);
    cmp_count++;
    if (seen !== expd) begin
      failures++;
      $display("FAIL t=%0t seen=%h exp=%h", $time, seen, expd);
    end
  endtask
  // Conditions settle through two register stages before a read can see them.
  task automatic settle(input logic [17:0] n);
    c <= n;
    repeat (3) @(posedge mclk);
    m.xfer(1'b0, 4'h0, 32'h0, r);
  endtask
  task automatic complete_run;
    $display("failures=%0d cmp_count=%0d", failures, cmp_count);
    if (failures == 0 && cmp_count > 0)
      $display("Finished cleanly");
    else
      $display("Finished with errors");
    $finish;
  endtask
  always @(posedge mclk) begin
    ticks++;
    if (ticks == 3000) begin
      failures++;
      complete_run();
    end
  end
  initial begin
    c = '0;
    act = '0;
    resetn = 1'b0;
    repeat (4) @(posedge mclk);
    resetn <= 1'b1;
    @(posedge mclk);
    for (int i = 0; i < 18; i++) begin
      k = 18'h1 << i;
      if (i != 3 && i != 4) begin
        settle(k);
        check(r, exp_sw(k, act));
      end
    end
    settle(18'h1ffe7);
    check(r, exp_sw(18'h1ffe7, act));
    settle(18'h3ffe7);
    check(r, 32'h0);
    settle(18'h00009);
    check(r, 32'h8);
    settle(18'h00001);
    check({31'h0, r[3]}, 32'h1);
    settle(18'h00011);
    settle(18'h00001);
    check(r, 32'h1);
    act <= 16'hc000;
    settle(18'h0);
    check(r, 32'h800);
    m.xfer(1'b0, 4'h4, 32'h0, r);
    check(r, 32'hc000);
    foreach (refs[j]) begin
      v = refs[j];
      m16 = v[15] ? 16'h0000 - v : v;
      m.xfer(1'b1, 4'h8, {16'hffff, v}, r);
      check({sref, rev, mag}, {v, v[15], v == 16'h8000 ? 15'h7fff : m16[14:0]});
      m.xfer(1'b0, 4'h8, 32'h0, r);
      check(r, {16'h0000, v});
    end
    m.xfer(1'b1, 4'h0, 32'h1234, r);
    check({16'h0000, sref}, 32'h8000);
    m.xfer(1'b0, 4'h2, 32'h0, r);
    check(r, 32'h0);
    m.xfer(1'b1, 4'hc, 32'h1, r);
    m.xfer(1'b0, 4'hc, 32'h0, r);
    check(r, 32'h1);
    m.xfer(1'b1, 4'h8, 32'h7fff, r);
    check({16'h0000, sref}, 32'h4000);
    m.xfer(1'b1, 4'h8, 32'h8001, r);
    check({16'h0000, sref}, 32'hc000);
    complete_run();
  end
endmodule // testbench
